// *** logic/dc_actuator_open_close_control.sv ***
// open/close control of a dc valve actuator with timers, trip and leds
`timescale 1ns/1ps
//
// Contract
// - two-wire mode: open while the open command is high, else close.
// - three-wire mode: each input drives its own way, none holds position.
// - the repeat timer is enabled per direction by its own switch.
// - with the timer on, the output pulses on 0.2-2 s and off 0.5-10 s.
// - an adjustable delay separates a new command from output turn-on.
// - a command withdrawn during the delay never turns its output on.
// - local mode takes the onboard buttons in place of remote inputs.
// - red shows the open output active, green the close output active.
// - leds also show output on, limit reached, low and high supply.
// - blink is 0.4 s on/0.4 s off and flash is 10 cycles per second.
// - the motor stops once current passes the fixed or adjusted level.
// - a latched trip clears on reversal or on the grounded reset input.
// - the adjustable variant lights yellow and drives a contact on trip.
// - an open limit switch forbids further travel in that direction.
// - one output waits for the other to be off; both commands mean off in three-wire mode, open in two-wire mode.
module dc_actuator_open_close_control #(
	parameter bit adjustable_trip = 1'b1,
	parameter int unsigned ms_width = actuator_pkg::ms_w,
	parameter int unsigned tick_len = actuator_pkg::tick_cycles
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic open_button,
	input wire logic close_button,
	input wire logic open_limit_ok,
	input wire logic close_limit_ok,
	input wire logic over_current,
	input wire logic trip_reset_n,
	input wire logic supply_low,
	input wire logic supply_high,
	input wire logic [3:0] config_switch_bank,
	input wire logic [15:0] delay_ms,
	input wire logic [15:0] on_time_adjust,
	input wire logic [15:0] off_time_adjust,
	output logic motor_open,
	output logic motor_close,
	output logic led_red,
	output logic led_green,
	output logic led_yellow,
	output logic trip_contact
);
	import actuator_pkg::*;

	// the timer fields and the 18 bit tick counter bound these values
	if (ms_width != 16) begin : g_bad_width
		$error("ms_width must be 16");
	end
	if (tick_len < 2 || tick_len > 262144) begin : g_bad_tick
		$error("tick_len must be 2 to 262144");
	end

	// ==============================================
	// state
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [17:0] tick_cnt;
		logic [9:0] blink_cnt;
		logic blink;
		logic [6:0] flash_cnt;
		logic flash;
		logic tripped;
		logic last_dir;
		drive_state_t st_o;
		drive_state_t st_c;
		logic [15:0] t_o;
		logic [15:0] t_c;
		logic mo;
		logic mc;
		logic lr;
		logic lg;
		logic ly;
	} state_t;

	state_t q_r, q_nxt;
	logic [7:0] pins;
	logic tick, cmd_o, cmd_c, want_o, want_c;
	logic b_o, b_c, lim_o, lim_c, trip_in, rst_ok, low, high;
	logic [15:0] on_ms, off_ms;

	// ==============================================
	// input synchronisers
	assign pins = {open_cmd, close_cmd, open_button, close_button,
		open_limit_ok, close_limit_ok, over_current, trip_reset_n};
	assign {cmd_o, cmd_c, b_o, b_c, lim_o, lim_c, trip_in, rst_ok} = q_r.s2;
	// supply monitor flags come from on-chip logic on this clock
	assign low = supply_low;
	assign high = supply_high;
	assign tick = (q_r.tick_cnt == 18'(tick_len - 1));

	// clamp knob values into the printed ranges
	assign on_ms = (on_time_adjust < 16'(on_min_ms)) ? 16'(on_min_ms) :
		(on_time_adjust > 16'(on_max_ms)) ? 16'(on_max_ms) :
		on_time_adjust;
	assign off_ms = (off_time_adjust < 16'(off_min_ms)) ? 16'(off_min_ms) :
		(off_time_adjust > 16'(off_max_ms)) ? 16'(off_max_ms) :
		off_time_adjust;

	// ==============================================
	// command selection
	logic src_o, src_c, loc, three;
	always_comb begin
		loc = config_switch_bank[sw_local];
		three = config_switch_bank[sw_three_wire] | loc;
		src_o = loc ? b_o : cmd_o;
		src_c = loc ? b_c : cmd_c;
		if (three) begin
			want_o = src_o & ~src_c;
			want_c = src_c & ~src_o;
		end else begin
			want_o = src_o;
			want_c = ~src_o;
		end
	end

	// one direction's sequencer: idle, delay, on, off
	function automatic void step(
		input drive_state_t st,
		input logic [15:0] t,
		input logic want,
		input logic ok,
		input logic other_off,
		input logic timer_en,
		input logic tk,
		input logic [15:0] dly,
		input logic [15:0] ton,
		input logic [15:0] toff,
		output drive_state_t st_n,
		output logic [15:0] t_n,
		output logic drive
	);
		st_n = st;
		t_n = (tk && t != 16'h0000) ? t - 16'h0001 : t;
		drive = 1'b0;
		if (!want) begin
			st_n = st_idle;
			t_n = 16'h0000;
		end else begin
			case (st)
				st_idle: begin
					if (other_off) begin
						st_n = st_delay;
						t_n = dly;
					end
				end
				st_delay: begin
					if (t == 16'h0000) begin
						st_n = st_on;
						t_n = ton;
					end
				end
				st_on: begin
					drive = ok;
					if (timer_en && t == 16'h0000) begin
						st_n = st_off;
						t_n = toff;
					end
				end
				st_off: begin
					if (t == 16'h0000) begin
						st_n = st_on;
						t_n = ton;
					end
				end
				default: st_n = st_idle;
			endcase
		end
	endfunction : step

	// ==============================================
	// next state
	always_comb begin
		drive_state_t so, sc;
		logic [15:0] to, tc;
		logic dro, drc, ok;
		ok = 1'b0;
		q_nxt = q_r;
		so = st_idle;
		sc = st_idle;
		to = 16'h0000;
		tc = 16'h0000;
		dro = 1'b0;
		drc = 1'b0;
		q_nxt.s1 = pins;
		q_nxt.s2 = q_r.s1;
		q_nxt.tick_cnt = tick ? 18'h0_0000 : q_r.tick_cnt + 18'h0_0001;
		if (tick) begin
			if (q_r.blink_cnt == 10'(blink_half_ticks - 1)) begin
				q_nxt.blink_cnt = 10'h000;
				q_nxt.blink = ~q_r.blink;
			end else
				q_nxt.blink_cnt = q_r.blink_cnt + 10'h001;
			if (q_r.flash_cnt == 7'(flash_half_ticks - 1)) begin
				q_nxt.flash_cnt = 7'h00;
				q_nxt.flash = ~q_r.flash;
			end else
				q_nxt.flash_cnt = q_r.flash_cnt + 7'h01;
		end
		// trip latch; a new trip wins over a clear in the same cycle
		if (want_o)
			q_nxt.last_dir = 1'b1;
		else if (want_c)
			q_nxt.last_dir = 1'b0;
		if ((want_o && !q_r.last_dir) || (want_c && q_r.last_dir) || !rst_ok)
			q_nxt.tripped = 1'b0;
		if (trip_in)
			q_nxt.tripped = 1'b1;
		ok = ~q_r.tripped & ~low & ~high;
		step(q_r.st_o, q_r.t_o, want_o, ok & lim_o, ~q_r.mc,
			config_switch_bank[sw_open_timer], tick, delay_ms, on_ms, off_ms,
			so, to, dro);
		step(q_r.st_c, q_r.t_c, want_c, ok & lim_c, ~q_r.mo,
			config_switch_bank[sw_close_timer], tick, delay_ms, on_ms, off_ms,
			sc, tc, drc);
		q_nxt.st_o = so;
		q_nxt.st_c = sc;
		q_nxt.t_o = to;
		q_nxt.t_c = tc;
		q_nxt.mo = dro & ~q_r.mc & ~trip_in;
		q_nxt.mc = drc & ~q_r.mo & ~trip_in;
		// led priority: overvoltage, low supply, limit, output state
		if (high) begin
			q_nxt.lr = 1'b1;
			q_nxt.lg = 1'b1;
		end else if (low) begin
			q_nxt.lr = q_r.blink;
			q_nxt.lg = q_r.blink;
		end else begin
			// follow the gated outputs so a lamp never shows a refused drive
			q_nxt.lr = !lim_o ? q_r.flash : q_nxt.mo;
			q_nxt.lg = !lim_c ? q_r.flash : q_nxt.mc;
		end
		q_nxt.ly = adjustable_trip & q_r.tripped;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	// ==============================================
	// outputs
	assign motor_open = q_r.mo;
	assign motor_close = q_r.mc;
	assign led_red = q_r.lr;
	assign led_green = q_r.lg;
	assign led_yellow = q_r.ly;
	assign trip_contact = q_r.ly;
endmodule : dc_actuator_open_close_control

// *** logic/actuator_pkg.sv ***
// constants shared by the valve actuator control block
package actuator_pkg;
	localparam int unsigned clk_hz = 200_000_000;
	// blink 0.4 s on / 0.4 s off, flash 10 cycles per second
	localparam int unsigned blink_half_ms = 400;
	localparam int unsigned flash_hz = 10;
	localparam int unsigned tick_ms = 1;
	localparam int unsigned tick_cycles = clk_hz / 1000 * tick_ms;
	localparam int unsigned blink_half_ticks = blink_half_ms / tick_ms;
	localparam int unsigned flash_half_ticks = 1000 / (flash_hz * 2) / tick_ms;
	// repeat timer bounds, in milliseconds
	localparam int unsigned on_min_ms = 200;
	localparam int unsigned on_max_ms = 2000;
	localparam int unsigned off_min_ms = 500;
	localparam int unsigned off_max_ms = 10000;
	// current trip level limit in amperes
	localparam int unsigned trip_max_amps = 12;
	localparam int unsigned ms_w = 16;
	localparam logic [3:0] trip_fixed_amps = 4'hc;
	// configuration switch bank field positions
	localparam int unsigned sw_open_timer = 0;
	localparam int unsigned sw_close_timer = 1;
	localparam int unsigned sw_three_wire = 2;
	localparam int unsigned sw_local = 3;
	typedef enum logic [1:0] {
		st_idle,
		st_delay,
		st_on,
		st_off
	} drive_state_t;
endpackage : actuator_pkg

// *** testbench/actuator_checker_assertions.sv ***
// pin level assertions for the actuator control block
`timescale 1ns/1ps
module actuator_checker (
	input wire logic clock,
	input wire logic rstn,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic open_limit_ok,
	input wire logic close_limit_ok,
	input wire logic over_current,
	input wire logic supply_low,
	input wire logic [3:0] config_switch_bank,
	input wire logic motor_open,
	input wire logic motor_close,
	input wire logic led_red,
	input wire logic led_yellow,
	input wire logic trip_contact
);
	// ==========
	// properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	chk_no_overlap: assert property (
		!(motor_open && motor_close))
		else $error("both motor outputs on");
	chk_start_off: assert property (
		$rose(rstn) |-> !motor_open && !motor_close)
		else $error("output on at reset release");
	// a few cycles of slack cover the input synchroniser
	chk_trip_stops: assert property (
		over_current[*6] |-> !motor_open && !motor_close)
		else $error("motor runs during trip");
	chk_trip_leds: assert property (
		over_current[*6] |-> led_yellow && trip_contact)
		else $error("trip not shown");
	chk_open_limit: assert property (
		(!open_limit_ok)[*6] |-> !motor_open)
		else $error("open past limit");
	chk_close_limit: assert property (
		(!close_limit_ok)[*6] |-> !motor_close)
		else $error("close past limit");
	chk_low_supply: assert property (
		supply_low[*3] |-> !motor_open && !motor_close)
		else $error("motor runs on low supply");
	chk_both_cmds: assert property (
		(config_switch_bank[3:2] == 2'h1 && open_cmd && close_cmd)[*6]
		|-> !motor_open && !motor_close)
		else $error("both commands not refused");
	chk_red_shows: assert property (
		$rose(motor_open) |-> ##[0:2] led_red)
		else $error("red not lit");
	cover property ($rose(motor_open));
	cover property ($rose(motor_close));
	cover property ($rose(led_yellow));
endmodule : actuator_checker
bind dc_actuator_open_close_control actuator_checker chk_u (.clock(clock),
	.rstn(rstn), .open_cmd(open_cmd), .close_cmd(close_cmd),
	.open_limit_ok(open_limit_ok), .close_limit_ok(close_limit_ok),
	.over_current(over_current), .supply_low(supply_low),
	.config_switch_bank(config_switch_bank), .motor_open(motor_open),
	.motor_close(motor_close), .led_red(led_red), .led_yellow(led_yellow),
	.trip_contact(trip_contact));

// *** testbench/controller_model.sv ***
// external controller model driving the command and trip reset inputs
`timescale 1ns/1ps
module controller_model (
	input wire logic clock,
	input wire logic [1:0] want,
	input wire logic clear_trip,
	output logic open_cmd,
	output logic close_cmd,
	output logic trip_reset_n
);
	initial {open_cmd, close_cmd, trip_reset_n} = 3'h1;
	// requests are taken at the edge and shown just after it, so the
	// bench's own updates one step past the edge never race the model
	always @(posedge clock) begin
		{open_cmd, close_cmd} <= #1 want;
		trip_reset_n <= #1 !clear_trip;
	end
endmodule : controller_model

// *** testbench/dc_actuator_open_close_control_bench.sv ***
// self-checking bench for the actuator control block
`timescale 1ns/1ps
module dc_actuator_open_close_control_bench;
	logic clock = 0, rstn = 0, oc, cc, ob = 0, cb = 0, olim = 1, clim = 1;
	logic trip = 0, low = 0, clr = 0, mo, mc, red, grn, yel, con, trn;
	logic [1:0] want = 2'h0;
	logic [3:0] cfg = 4'h0;
	logic high = 0;
	logic [15:0] dly = 16'h0000;
	logic [1:0] snap;
	int fails = 0, check_count = 0;
	always #2.5 clock = !clock;
	controller_model ctl_u (.clock(clock), .want(want), .clear_trip(clr),
		.open_cmd(oc), .close_cmd(cc), .trip_reset_n(trn));
	// a 20 cycle millisecond keeps the second-long timers in a short run
	dc_actuator_open_close_control #(.tick_len(20)) dut_u (.clock(clock),
		.rstn(rstn),
		.open_cmd(oc), .close_cmd(cc), .open_button(ob), .close_button(cb),
		.open_limit_ok(olim), .close_limit_ok(clim), .over_current(trip),
		.trip_reset_n(trn), .supply_low(low), .supply_high(high),
		.config_switch_bank(cfg), .delay_ms(dly),
		.on_time_adjust(16'h00c8), .off_time_adjust(16'h01f4),
		.motor_open(mo), .motor_close(mc), .led_red(red), .led_green(grn),
		.led_yellow(yel), .trip_contact(con));
	// ==========
	// tasks
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %b expected %b", $time, seen, exp);
		end
	endtask : check
	// bounded wait, since the start delay rounds down to the 1 ms tick
	task automatic wait_out(input logic [1:0] exp);
		int n = 0;
		while ({mo, mc} !== exp && n < 12000) begin
			@(posedge clock);
			#1;
			n++;
		end
		repeat (3) @(posedge clock);
		#1;
		check({mo, mc}, exp);
	endtask : wait_out
	task automatic end_sim;
		$display("fails %0d check_count %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// ==========
	// tests
	initial begin
		repeat (16) @(posedge clock);
		#1;
		check({mo, mc}, 2'h0);
		rstn = 1;
		wait_out(2'h1);
		check({red, grn}, 2'h1);
		want = 2'h2;
		wait_out(2'h2);
		check({red, grn}, 2'h2);
		cfg = 4'h4;
		want = 2'h0;
		wait_out(2'h0);
		want = 2'h2;
		wait_out(2'h2);
		olim = 0;
		wait_out(2'h0);
		snap = {red, grn};
		repeat (1000) @(posedge clock);
		#1;
		check({red, grn}, snap ^ 2'h2);
		olim = 1;
		wait_out(2'h2);
		want = 2'h1;
		wait_out(2'h1);
		clim = 0;
		wait_out(2'h0);
		clim = 1;
		wait_out(2'h1);
		want = 2'h3;
		wait_out(2'h0);
		want = 2'h1;
		wait_out(2'h1);
		trip = 1;
		wait_out(2'h0);
		trip = 0;
		repeat (8) @(posedge clock);
		#1;
		wait_out(2'h0);
		check({yel, con}, 2'h3);
		clr = 1;
		wait_out(2'h1);
		check({yel, con}, 2'h0);
		clr = 0;
		trip = 1;
		wait_out(2'h0);
		trip = 0;
		repeat (8) @(posedge clock);
		#1;
		want = 2'h2;
		wait_out(2'h2);
		cfg = 4'h8;
		cb = 1;
		wait_out(2'h1);
		cb = 0;
		ob = 1;
		wait_out(2'h2);
		ob = 0;
		cfg = 4'h4;
		want = 2'h0;
		dly = 16'h0064;
		wait_out(2'h0);
		want = 2'h2;
		repeat (1900) @(posedge clock);
		#1;
		check({mo, mc}, 2'h0);
		wait_out(2'h2);
		want = 2'h0;
		wait_out(2'h0);
		want = 2'h2;
		repeat (1000) @(posedge clock);
		#1;
		want = 2'h0;
		repeat (2000) @(posedge clock);
		#1;
		check({mo, mc}, 2'h0);
		dly = 16'h0000;
		cfg = 4'h5;
		want = 2'h2;
		wait_out(2'h2);
		repeat (3900) @(posedge clock);
		#1;
		check({mo, mc}, 2'h2);
		wait_out(2'h0);
		repeat (9800) @(posedge clock);
		#1;
		check({mo, mc}, 2'h0);
		wait_out(2'h2);
		low = 1;
		wait_out(2'h0);
		snap = {red, grn};
		check({red, red}, {grn, grn});
		repeat (8000) @(posedge clock);
		#1;
		check({red, grn}, ~snap);
		low = 0;
		high = 1;
		wait_out(2'h0);
		check({red, grn}, 2'h3);
		end_sim();
	end
	// the scenarios take about 28000 cycles
	initial begin
		repeat (80000) @(posedge clock);
		fails++;
		end_sim();
	end
endmodule : dc_actuator_open_close_control_bench
